// File: ehl_error_history_log.sv
// error code registers and sequential error history with read buffer
//
// Notes on behaviour
// - class 0 code register, zero when none
// - class 0 code held until fault clear
// - separate register holds last stopping error code
// - history keeps the last ten errors
// - history survives the working reset
// - record captures snapshot at detection time
// - history read only in sequence by pointer
// - writing one rewinds pointer to oldest
// - entry code read copies record into buffer
// - entry code read advances the pointer
// - reading past last record returns zero
// - oldest record first, newest last
// - buffered class is zero to four
// - current field is unsigned, 0.01 A steps
// - bus voltage field is unsigned, 0.1 V steps
// - error time saturates at 536870911 seconds
// - clear on write one, reads zero when done
// - power-on count is unsigned 32-bit
// - enable count captured at error time
// - qualifier is unsigned 16-bit, code-dependent
`timescale 1ns/100ps
`default_nettype none
module ehl_error_history_log #(
    parameter int DEPTH = ehl_pkg::EHL_HIST_DEPTH
) (
    input  wire logic        core_clk,      // 125 MHz clock
    input  wire logic        rst,           // async reset, high
    input  wire logic        store_rst,     // blank history init
    input  wire logic        err_valid,     // error detected pulse
    input  wire logic [2:0]  err_class,     // error class 0..4
    input  wire logic [15:0] err_code,      // error code
    input  wire logic [15:0] err_qual,      // qualifier
    input  wire logic [31:0] err_time,      // operating hours, s
    input  wire logic [31:0] power_on_cnt,  // power-up cycles
    input  wire logic [15:0] enable_cnt,    // enable cycles since on
    input  wire logic [15:0] enable_time,   // enable to error, s
    input  wire logic [15:0] bus_volt,      // dc bus, 0.1 V
    input  wire logic [15:0] motor_speed,   // velocity, signed
    input  wire logic [15:0] motor_cur,     // current, 0.01 A
    input  wire logic [15:0] stage_temp,    // power stage temp
    input  wire logic [15:0] dev_temp,      // device temp
    input  wire logic        fault_reset,   // fault clear pulse
    input  wire logic        reg_rd,        // parameter read
    input  wire logic        reg_wr,        // parameter write
    input  wire logic [15:0] reg_addr,      // parameter address
    input  wire logic [15:0] reg_wdata,     // write value
    output logic      [31:0] reg_rdata,     // read value
    output logic             reg_rvalid     // read answer strobe
);
    import ehl_pkg::*;

    // ******************************************************************
    // elaboration checks
    // ******************************************************************
    if (DEPTH < 2 || DEPTH > (1 << EHL_IDX_W) - 2) begin : g_chk
        $error("DEPTH out of range for the pointer width");
    end

    localparam int CLR_BOUND = 12;

    // ******************************************************************
    // declarations
    // ******************************************************************
    logic [15:0]          minor_code;
    logic [15:0]          stop_code;
    ehl_rec_t             new_rec;
    ehl_rec_t             rd_rec;
    logic [EHL_IDX_W-1:0] count;
    logic                 busy;
    logic [EHL_IDX_W-1:0] rptr_q;
    ehl_rec_t             buf_q;
    logic [31:0]          rdata_q;
    logic                 rvalid_q;
    logic [31:0]          rdata_d;
    logic                 rec_ok;
    logic                 code_rd;
    logic                 code_hit;
    logic                 rewind_wr;
    logic                 clear_wr;
    logic [EHL_TIME_W-1:0] time_sat;

    // ******************************************************************
    // last error codes
    // ******************************************************************
    ehl_code_latch u_codes (
        .core_clk    (core_clk),
        .rst         (rst),
        .err_valid   (err_valid),
        .err_class   (err_class),
        .err_code    (err_code),
        .fault_reset (fault_reset),
        .minor_code  (minor_code),
        .stop_code   (stop_code)
    );

    // ******************************************************************
    // record capture
    // ******************************************************************
    // out-of-range classes are not errors and are not logged
    assign rec_ok   = err_valid && err_class <= EHL_CLASS_MAX;
    // hours counter clipped rather than wrapped
    assign time_sat = (err_time > 32'(EHL_TIME_W'('1)))
                      ? EHL_TIME_W'('1)
                      : err_time[EHL_TIME_W-1:0];

    always_comb begin
        new_rec = '0;
        new_rec[EHL_F_CODE   +: 16]          = err_code;
        new_rec[EHL_F_QUAL   +: 16]          = err_qual;
        new_rec[EHL_F_ENCYC  +: 16]          = enable_cnt;
        new_rec[EHL_F_ENTIME +: 16]          = enable_time;
        new_rec[EHL_F_UDC    +: 16]          = bus_volt;
        new_rec[EHL_F_SPEED  +: 16]          = motor_speed;
        new_rec[EHL_F_CUR    +: 16]          = motor_cur;
        new_rec[EHL_F_TPA    +: 16]          = stage_temp;
        new_rec[EHL_F_TDEV   +: 16]          = dev_temp;
        new_rec[EHL_F_TIME   +: EHL_TIME_W]  = time_sat;
        new_rec[EHL_F_PON    +: 32]          = power_on_cnt;
        new_rec[EHL_F_CLASS  +: EHL_CLASS_W] = err_class;
    end

    // ******************************************************************
    // history store
    // ******************************************************************
    // store has its own reset so the working reset leaves it intact
    ehl_hist_store #(
        .DEPTH (DEPTH)
    ) u_store (
        .core_clk    (core_clk),
        .store_rst   (store_rst),
        .wr_en       (rec_ok),
        .wr_rec      (new_rec),
        .clear_start (clear_wr),
        .rd_idx      (rptr_q),
        .rd_rec      (rd_rec),
        .count       (count),
        .busy        (busy)
    );

    // ******************************************************************
    // parameter access decode
    // ******************************************************************
    assign code_rd   = reg_rd && reg_addr == EHL_ADDR_ENTRY_CODE;
    assign code_hit  = code_rd && rptr_q < count;
    assign rewind_wr = reg_wr && reg_addr == EHL_ADDR_REWIND
                       && reg_wdata == EHL_CMD_SET;
    assign clear_wr  = reg_wr && reg_addr == EHL_ADDR_CLEAR
                       && reg_wdata == EHL_CMD_SET && !busy;

    // pointer only moves by rewind, clear or entry code reads
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rptr_q <= '0;
        end else if (rewind_wr || clear_wr) begin
            rptr_q <= '0;
        end else if (code_hit) begin
            rptr_q <= rptr_q + 1'b1;
        end
    end

    // details come from this copy, not live from the store
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buf_q <= '0;
        end else if (code_hit) begin
            buf_q <= rd_rec;
        end
    end

    always_comb begin
        rdata_d = EHL_RD_RESET;
        case (reg_addr)
            EHL_ADDR_STOP_CODE:   rdata_d = {16'h0000, stop_code};
            EHL_ADDR_MINOR_CODE:  rdata_d = {16'h0000, minor_code};
            EHL_ADDR_POWER_ON:    rdata_d = buf_q[EHL_F_PON +: 32];
            EHL_ADDR_CLEAR:       rdata_d = {31'h00000000, busy};
            EHL_ADDR_REWIND:      rdata_d = EHL_RD_RESET;
            EHL_ADDR_ENTRY_CODE: begin
                if (code_hit) begin
                    rdata_d = {16'h0000, rd_rec[EHL_F_CODE +: 16]};
                end
            end
            EHL_ADDR_ENTRY_CLASS:
                rdata_d = {29'h00000000, buf_q[EHL_F_CLASS +: EHL_CLASS_W]};
            EHL_ADDR_ERR_TIME:
                rdata_d = {3'h0, buf_q[EHL_F_TIME +: EHL_TIME_W]};
            EHL_ADDR_QUALIFIER:   rdata_d = {16'h0000, buf_q[EHL_F_QUAL +: 16]};
            EHL_ADDR_EN_COUNT:    rdata_d = {16'h0000, buf_q[EHL_F_ENCYC +: 16]};
            EHL_ADDR_EN_TIME:     rdata_d = {16'h0000, buf_q[EHL_F_ENTIME +: 16]};
            EHL_ADDR_BUS_VOLT:    rdata_d = {16'h0000, buf_q[EHL_F_UDC +: 16]};
            EHL_ADDR_SPEED:       rdata_d = {16'h0000, buf_q[EHL_F_SPEED +: 16]};
            EHL_ADDR_CURRENT:     rdata_d = {16'h0000, buf_q[EHL_F_CUR +: 16]};
            EHL_ADDR_STAGE_TEMP:  rdata_d = {16'h0000, buf_q[EHL_F_TPA +: 16]};
            EHL_ADDR_DEV_TEMP:    rdata_d = {16'h0000, buf_q[EHL_F_TDEV +: 16]};
            default:              rdata_d = EHL_RD_RESET;
        endcase
    end

    // answer one cycle after the read; unmapped addresses read zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_q  <= EHL_RD_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // ******************************************************************
    // checks
    // ******************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst || store_rst);

    minor_set_a: assert property (
        err_valid && err_class == 3'h0
        |=> u_codes.minor_code == $past(err_code))
        else $error("class 0 code not captured");

    minor_hold_a: assert property (
        !err_valid && !fault_reset |=> $stable(minor_code))
        else $error("class 0 code changed without cause");

    stop_set_a: assert property (
        err_valid && err_class != 3'h0 && err_class <= EHL_CLASS_MAX
        |=> stop_code == $past(err_code))
        else $error("stopping code not captured");

    count_cap_a: assert property (
        count <= EHL_IDX_W'(DEPTH))
        else $error("history holds more than depth records");

    full_keep_a: assert property (
        rec_ok && !busy && !clear_wr && count == EHL_IDX_W'(DEPTH)
        |=> count == EHL_IDX_W'(DEPTH))
        else $error("full history lost a record on append");

    rewind_ptr_a: assert property (
        rewind_wr |=> rptr_q == '0)
        else $error("rewind did not reset pointer");

    ptr_advance_a: assert property (
        code_hit && !rewind_wr && !clear_wr
        |=> rptr_q == $past(rptr_q) + 1'b1)
        else $error("pointer did not advance on code read");

    buf_load_a: assert property (
        code_hit |=> buf_q == $past(rd_rec) && reg_rvalid)
        else $error("holding buffer not loaded");

    end_read_a: assert property (
        code_rd && rptr_q >= count
        |=> reg_rvalid && reg_rdata == EHL_RD_RESET)
        else $error("read past last entry not zero");

    clear_done_a: assert property (
        clear_wr |=> busy ##[1:CLR_BOUND] !busy)
        else $error("history clear did not complete");

    class_range_a: assert property (
        buf_q[EHL_F_CLASS +: EHL_CLASS_W] <= EHL_CLASS_MAX)
        else $error("buffered class out of range");

    time_cap_a: assert property (
        reg_rvalid && $past(reg_addr) == EHL_ADDR_ERR_TIME
        |-> reg_rdata <= 32'h1FFFFFFF)
        else $error("error time beyond limit");

    minor_clear_a: assert property (
        fault_reset && !(err_valid && err_class == 3'h0)
        |=> minor_code == EHL_CODE_NONE)
        else $error("class 0 code not cleared");

    stop_keep_a: assert property (
        !err_valid |=> $stable(stop_code))
        else $error("stopping code changed without cause");

    buf_keep_a: assert property (
        !code_hit |=> $stable(buf_q))
        else $error("holding buffer changed without code read");

    end_hold_a: assert property (
        code_rd && rptr_q >= count |=> $stable(rptr_q))
        else $error("pointer moved past last entry");

    clear_empty_a: assert property (
        clear_wr |=> count == '0 && rptr_q == '0)
        else $error("clear did not empty the history");

    wipe_drop_a: assert property (
        busy |=> count == '0)
        else $error("record stored during clear");

endmodule
`default_nettype wire

// File: ehl_pkg.sv
// constants and types shared by the error history log block
package ehl_pkg;

    // ******************************************************************
    // parameter addresses, as seen on the fieldbus parameter port
    // ******************************************************************
    localparam logic [15:0] EHL_ADDR_STOP_CODE   = 16'h1C0A;
    localparam logic [15:0] EHL_ADDR_MINOR_CODE  = 16'h1C12;
    localparam logic [15:0] EHL_ADDR_POWER_ON    = 16'h3B04;
    localparam logic [15:0] EHL_ADDR_CLEAR       = 16'h3B08;
    localparam logic [15:0] EHL_ADDR_REWIND      = 16'h3B0A;
    localparam logic [15:0] EHL_ADDR_ENTRY_CODE  = 16'h3C02;
    localparam logic [15:0] EHL_ADDR_ENTRY_CLASS = 16'h3C04;
    localparam logic [15:0] EHL_ADDR_ERR_TIME    = 16'h3C06;
    localparam logic [15:0] EHL_ADDR_QUALIFIER   = 16'h3C08;
    localparam logic [15:0] EHL_ADDR_EN_COUNT    = 16'h3C0A;
    localparam logic [15:0] EHL_ADDR_EN_TIME     = 16'h3C0C;
    localparam logic [15:0] EHL_ADDR_BUS_VOLT    = 16'h3C0E;
    localparam logic [15:0] EHL_ADDR_SPEED       = 16'h3C10;
    localparam logic [15:0] EHL_ADDR_CURRENT     = 16'h3C12;
    localparam logic [15:0] EHL_ADDR_STAGE_TEMP  = 16'h3C14;
    localparam logic [15:0] EHL_ADDR_DEV_TEMP    = 16'h3C16;

    // ******************************************************************
    // sizes and values
    // ******************************************************************
    localparam int          EHL_HIST_DEPTH = 10;
    localparam int          EHL_IDX_W      = 4;
    localparam int          EHL_CLASS_W    = 3;
    localparam int          EHL_TIME_W     = 29;
    localparam logic [2:0]  EHL_CLASS_MAX  = 3'h4;
    localparam logic [15:0] EHL_CMD_SET    = 16'h0001;
    localparam logic [15:0] EHL_CODE_NONE  = 16'h0000;
    localparam logic [31:0] EHL_RD_RESET   = 32'h00000000;

    // ******************************************************************
    // record layout: field lsb positions
    // ******************************************************************
    localparam int EHL_F_CODE   = 0;
    localparam int EHL_F_QUAL   = 16;
    localparam int EHL_F_ENCYC  = 32;
    localparam int EHL_F_ENTIME = 48;
    localparam int EHL_F_UDC    = 64;
    localparam int EHL_F_SPEED  = 80;
    localparam int EHL_F_CUR    = 96;
    localparam int EHL_F_TPA    = 112;
    localparam int EHL_F_TDEV   = 128;
    localparam int EHL_F_TIME   = 144;
    localparam int EHL_F_PON    = 173;
    localparam int EHL_F_CLASS  = 205;
    localparam int EHL_REC_W    = 208;

    typedef logic [EHL_REC_W-1:0] ehl_rec_t;

    typedef enum logic [1:0] {
        EHL_IDLE = 2'b01,
        EHL_WIPE = 2'b10
    } ehl_clr_state_t;

endpackage

// File: ehl_code_latch.sv
// latches of the most recent class 0 and stopping error codes
`timescale 1ns/100ps
`default_nettype none
module ehl_code_latch (
    input  wire logic        core_clk,    // system clock
    input  wire logic        rst,         // async reset, high
    input  wire logic        err_valid,   // error detected pulse
    input  wire logic [2:0]  err_class,   // class of that error
    input  wire logic [15:0] err_code,    // code of that error
    input  wire logic        fault_reset, // fault clear pulse
    output logic      [15:0] minor_code,  // last class 0 code
    output logic      [15:0] stop_code    // last class 1..4 code
);
    import ehl_pkg::*;

    logic [15:0] minor_q;
    logic [15:0] stop_q;

    // a new class 0 error in the clearing cycle wins over the clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            minor_q <= EHL_CODE_NONE;
        end else if (err_valid && err_class == 3'h0) begin
            minor_q <= err_code;
        end else if (fault_reset) begin
            minor_q <= EHL_CODE_NONE;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stop_q <= EHL_CODE_NONE;
        end else if (err_valid && err_class != 3'h0
                     && err_class <= EHL_CLASS_MAX) begin
            stop_q <= err_code;
        end
    end

    assign minor_code = minor_q;
    assign stop_code  = stop_q;
endmodule
`default_nettype wire

// File: ehl_hist_store.sv
// ring store of error records, retained across the working reset
`timescale 1ns/100ps
`default_nettype none
module ehl_hist_store #(
    parameter int DEPTH = 10
) (
    input  wire logic                     core_clk,    // system clock
    input  wire logic                     store_rst,   // blank-store init
    input  wire logic                     wr_en,       // append record
    input  wire ehl_pkg::ehl_rec_t        wr_rec,      // record to append
    input  wire logic                     clear_start, // begin wipe
    input  wire logic [ehl_pkg::EHL_IDX_W-1:0] rd_idx, // 0 = oldest
    output ehl_pkg::ehl_rec_t             rd_rec,      // record at rd_idx
    output logic [ehl_pkg::EHL_IDX_W-1:0] count,       // records held
    output logic                          busy         // wipe running
);
    import ehl_pkg::*;

    ehl_rec_t               mem_q [DEPTH];
    logic [EHL_IDX_W-1:0]   head_q;
    logic [EHL_IDX_W-1:0]   count_q;
    logic [EHL_IDX_W-1:0]   wipe_q;
    ehl_clr_state_t         state_q;
    logic [EHL_IDX_W-1:0]   wr_slot;
    logic                   wr_ok;

    function automatic logic [EHL_IDX_W-1:0] slot(
        input logic [EHL_IDX_W-1:0] base,
        input logic [EHL_IDX_W-1:0] off
    );
        logic [EHL_IDX_W:0] s;
        s = {1'b0, base} + {1'b0, off};
        if (s >= (EHL_IDX_W+1)'(DEPTH)) begin
            s = s - (EHL_IDX_W+1)'(DEPTH);
        end
        return s[EHL_IDX_W-1:0];
    endfunction

    // errors arriving while the wipe runs are dropped
    assign wr_ok   = wr_en && state_q == EHL_IDLE && !clear_start;
    assign wr_slot = (count_q < EHL_IDX_W'(DEPTH)) ? slot(head_q, count_q)
                                                  : head_q;

    always_ff @(posedge core_clk or posedge store_rst) begin
        if (store_rst) begin
            state_q <= EHL_IDLE;
            wipe_q  <= '0;
        end else begin
            case (state_q)
                EHL_IDLE: begin
                    if (clear_start) begin
                        state_q <= EHL_WIPE;
                        wipe_q  <= '0;
                    end
                end
                EHL_WIPE: begin
                    if (wipe_q == EHL_IDX_W'(DEPTH - 1)) begin
                        state_q <= EHL_IDLE;
                    end
                    wipe_q <= wipe_q + 1'b1;
                end
                default: state_q <= EHL_IDLE;
            endcase
        end
    end

    // full store drops the oldest record by moving the head on
    always_ff @(posedge core_clk or posedge store_rst) begin
        if (store_rst) begin
            head_q  <= '0;
            count_q <= '0;
        end else if (clear_start) begin
            head_q  <= '0;
            count_q <= '0;
        end else if (wr_ok) begin
            if (count_q < EHL_IDX_W'(DEPTH)) begin
                count_q <= count_q + 1'b1;
            end else begin
                head_q <= slot(head_q, EHL_IDX_W'(1));
            end
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
        always_ff @(posedge core_clk or posedge store_rst) begin
            if (store_rst) begin
                mem_q[i] <= '0;
            end else if (state_q == EHL_WIPE && wipe_q == EHL_IDX_W'(i)) begin
                mem_q[i] <= '0;
            end else if (wr_ok && wr_slot == EHL_IDX_W'(i)) begin
                mem_q[i] <= wr_rec;
            end
        end
    end

    assign rd_rec = mem_q[slot(head_q, rd_idx)];
    assign count  = count_q;
    assign busy   = state_q == EHL_WIPE;

    // a full store that keeps its head would read the newest record back as the oldest
    oldest_drop_a: assert property (
        @(posedge core_clk) disable iff (store_rst)
        wr_ok && count_q == EHL_IDX_W'(DEPTH) |=> head_q != $past(head_q))
        else $error("full store kept its oldest record");
endmodule
`default_nettype wire

// File: ehl_master_model.sv
// fieldbus master model driving the parameter read and write port
`timescale 1ns/100ps
`default_nettype none
module ehl_master_model (
    input  wire logic        core_clk,   // system clock
    input  wire logic [31:0] reg_rdata,  // read value
    input  wire logic        reg_rvalid, // read answer strobe
    output logic             reg_rd,     // read request
    output logic             reg_wr,     // write request
    output logic      [15:0] reg_addr,   // parameter address
    output logic      [15:0] reg_wdata   // write value
);
    initial begin
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // released lines flip so a stale address never looks valid
    task automatic release_bus();
        reg_rd    <= 1'b0;
        reg_wr    <= 1'b0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        release_bus();
    endtask

    // bounded wait: ok stays low if no answer arrives
    task automatic rd(input logic [15:0] a, output logic [31:0] d,
                      output logic ok);
        ok = 1'b0;
        d  = 32'h00000000;
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        release_bus();
        for (int n = 0; n < 4 && !ok; n++) begin
            @(posedge core_clk);
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d  = reg_rdata;
            end
        end
    endtask
endmodule
`default_nettype wire

// File: ehl_error_history_log_tb.sv
// self-checking bench for the error history log
`timescale 1ns/100ps
`default_nettype none
module ehl_error_history_log_tb;
    import ehl_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        store_rst = 1'b1;
    logic        err_valid = 1'b0;
    logic        fault_reset = 1'b0;
    logic [2:0]  err_class = 3'h0;
    logic [15:0] err_code = 16'h0000;
    logic [31:0] err_time = 32'h00000000;
    logic [31:0] power_on_cnt = 32'h00000000;
    logic [15:0] snap [8] = '{default: 16'h0000};
    logic        reg_rd;
    logic        reg_wr;
    logic        reg_rvalid;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [31:0] reg_rdata;
    int          err_count = 0;
    int          tests_run = 0;

    always #4 core_clk = ~core_clk;

    ehl_error_history_log dut (
        .core_clk(core_clk), .rst(rst), .store_rst(store_rst),
        .err_valid(err_valid), .err_class(err_class), .err_code(err_code),
        .err_qual(snap[0]), .err_time(err_time),
        .power_on_cnt(power_on_cnt), .enable_cnt(snap[1]),
        .enable_time(snap[2]), .bus_volt(snap[3]), .motor_speed(snap[4]),
        .motor_cur(snap[5]), .stage_temp(snap[6]), .dev_temp(snap[7]),
        .fault_reset(fault_reset), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    ehl_master_model m (
        .core_clk(core_clk), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        m.rd(a, d, ok);
        if (ok !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED at %0t: no read answer", $time);
            complete_run();
        end else begin
            check(d, exp);
        end
    endtask

    // snapshot fields carry the event index so each record is unique
    task automatic log_err(input int i, input logic [2:0] cls);
        @(posedge core_clk);
        err_valid    <= 1'b1;
        err_class    <= cls;
        err_code     <= 16'h1000 + 16'(i);
        err_time     <= (i == 11) ? 32'hFFFFFFFF : 32'(i) * 32'h1000;
        power_on_cnt <= 32'h10000 + 32'(i);
        for (int k = 0; k < 8; k++) begin
            snap[k] <= {4'(k + 1), 12'(i)};
        end
        @(posedge core_clk);
        err_valid <= 1'b0;
    endtask

    task automatic read_entry(input int i);
        rd_chk(EHL_ADDR_ENTRY_CODE, 32'h1000 + 32'(i));
        rd_chk(EHL_ADDR_ENTRY_CLASS, 32'(i % 5));
        rd_chk(EHL_ADDR_ERR_TIME,
               (i == 11) ? 32'h1FFFFFFF : 32'(i) * 32'h1000);
        rd_chk(EHL_ADDR_POWER_ON, 32'h10000 + 32'(i));
        for (int k = 0; k < 8; k++) begin
            rd_chk(EHL_ADDR_QUALIFIER + 16'(2 * k),
                   {16'h0000, 4'(k + 1), 12'(i)});
        end
    endtask

    task automatic t_codes();
        log_err(20, 3'h0);
        log_err(21, 3'h3);
        rd_chk(EHL_ADDR_MINOR_CODE, 32'h1014);
        rd_chk(EHL_ADDR_STOP_CODE, 32'h1015);
        @(posedge core_clk);
        fault_reset <= 1'b1;
        @(posedge core_clk);
        fault_reset <= 1'b0;
        log_err(22, 3'h7);
        m.wr(EHL_ADDR_STOP_CODE, 16'h0001);
        rd_chk(EHL_ADDR_MINOR_CODE, 32'h0);
        rd_chk(EHL_ADDR_STOP_CODE, 32'h1015);
    endtask

    // clear with two records held; poll is bounded
    task automatic t_clear();
        logic [31:0] d;
        logic        ok;
        int          n;
        m.wr(EHL_ADDR_CLEAR, 16'h0002);
        rd_chk(EHL_ADDR_ENTRY_CODE, 32'h1014);
        m.wr(EHL_ADDR_REWIND, 16'h0002);
        rd_chk(EHL_ADDR_ENTRY_CODE, 32'h1015);
        rd_chk(EHL_ADDR_ENTRY_CODE, 32'h0);
        m.wr(EHL_ADDR_CLEAR, EHL_CMD_SET);
        rd_chk(EHL_ADDR_CLEAR, 32'h1);
        n = 0;
        do begin
            m.rd(EHL_ADDR_CLEAR, d, ok);
            n++;
        end while ((ok !== 1'b1 || d !== 32'h0) && n < 20);
        check({31'h0, ok}, 32'h1);
        check(d, 32'h0);
        if (ok !== 1'b1 || d !== 32'h0) begin
            complete_run();
        end else begin
            m.wr(EHL_ADDR_REWIND, EHL_CMD_SET);
            rd_chk(EHL_ADDR_ENTRY_CODE, 32'h0);
        end
    endtask

    task automatic t_history();
        for (int i = 0; i < 12; i++) begin
            log_err(i, 3'(i % 5));
        end
        m.wr(EHL_ADDR_REWIND, EHL_CMD_SET);
        for (int p = 0; p < 10; p++) begin
            read_entry(p + 2);
        end
        rd_chk(EHL_ADDR_ENTRY_CODE, 32'h0);
    endtask

    // working reset must leave the retained store intact
    task automatic t_retain();
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(EHL_ADDR_STOP_CODE, 32'h0);
        read_entry(2);
    endtask

    initial begin
        repeat (3) @(posedge core_clk);
        rst       <= 1'b0;
        store_rst <= 1'b0;
        rd_chk(EHL_ADDR_MINOR_CODE, 32'h0);
        rd_chk(EHL_ADDR_ENTRY_CODE, 32'h0);
        rd_chk(16'h3C18, 32'h0);
        t_codes();
        t_clear();
        t_history();
        t_retain();
        complete_run();
    end
endmodule
`default_nettype wire
